// [dv/dcd_bus_model.sv]
// behavioural model of the shared data bus answering the dma engine
`timescale 1ns/1ps
`default_nettype none
module dcd_bus_model (
    input  wire logic               clk_sys_i,
    input  wire logic               rst_n_i,
    input  wire dcd_pkg::dcd_mbus_t dma_bus_i,
    output logic [15:0]             rdata_o
);
    logic [15:0] idle_ff;

    // outside a read the line changes every cycle, so stale data never passes
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            idle_ff <= 16'h9c63;
        end else begin
            idle_ff <= ~idle_ff;
        end
    end

    // every address answers; software programs only real ones
    assign rdata_o = (dma_bus_i.req && !dma_bus_i.we) ? (dma_bus_i.addr ^ 16'h5a3c) : idle_ff;
endmodule // dcd_bus_model
`default_nettype wire

// [dv/tb_top.sv]
// self-checking testbench of the dual channel dma control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic               clk_sys_i = 1'b0;
    logic               rst_n_i   = 1'b0;
    logic               cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [17:0]        adr = 18'h00000;
    logic [3:0]         sel = 4'h0;
    logic [31:0]        dat = 32'h00000000;
    logic [31:0]        wb_dat_o;
    logic               wb_ack_o;
    logic [1:0]         xreq = 2'h0;
    logic               busy = 1'b0;
    logic [15:0]        rdata;
    dcd_pkg::dcd_mbus_t bus;
    logic               irq;
    logic [31:0]        seed = 32'h127e;
    logic [15:0]        rq[$];
    logic [32:0]        wq[$];
    int                 errors = 0, num_checks = 0, cycles = 0, irq_cnt = 0;

    initial begin
        forever #10 clk_sys_i = ~clk_sys_i;
    end

    dcd_top i_dcd_top (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .xfer_req_i(xreq), .cpu_bus_busy_i(busy), .dma_rdata_i(rdata),
        .dma_bus_o(bus), .dma_complete_irq_o(irq));
    dcd_bus_model i_dcd_bus_model (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .dma_bus_i(bus),
        .rdata_o(rdata));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    // expected bus write: unit, destination address, data read from source
    function automatic logic [32:0] ew(input logic w, input logic [15:0] a_wr, a_rd);
        return {w, a_wr, a_rd ^ 16'h5a3c};
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_sim;
        if (errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic wb(input logic w, input logic [15:0] idx, input logic [15:0] d);
        @(posedge clk_sys_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= {idx, 2'b00};
        sel <= 4'h3;
        dat <= {16'h0000, d};
        do @(posedge clk_sys_i); while (wb_ack_o !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [15:0] d);
        wb(1'b1, idx, d);
    endtask

    task automatic rd(input logic [15:0] idx, input logic [15:0] e);
        rq.push_back(e);
        wb(1'b0, idx, 16'h0000);
    endtask

    task automatic pulse(input logic [1:0] m);
        @(posedge clk_sys_i);
        xreq <= m;
        @(posedge clk_sys_i);
        xreq <= 2'h0;
    endtask

    // bounded wait until every expected bus write has been seen
    task automatic drain;
        int n;
        n = 0;
        while (wq.size() != 0 && n < 200) begin
            @(posedge clk_sys_i);
            n++;
        end
        chk("pending_writes", wq.size(), 0);
    endtask

    // background processor traffic holds the dma off the bus at random
    always @(posedge clk_sys_i) begin
        seed <= xs(seed);
        busy <= (seed[1:0] == 2'b00);
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            end_sim();
        end
    end

    always @(posedge clk_sys_i) begin
        logic [32:0] e;
        if (wb_ack_o === 1'b1 && we === 1'b0 && rq.size() != 0) begin
            chk("wb_read", wb_dat_o, {16'h0000, rq.pop_front()});
        end
        if (irq === 1'b1) begin
            irq_cnt++;
        end
        if (rst_n_i && bus.req === 1'b1 && bus.we === 1'b1 && busy === 1'b0) begin
            e = (wq.size() != 0) ? wq.pop_front() : 33'h1ffffffff;
            chk("bus_write", {bus.addr, e[32] ? bus.wdata : {8'h00, bus.wdata[7:0]}},
                {e[31:16], e[32] ? e[15:0] : {8'h00, e[7:0]}});
            chk("bus_unit", {31'h00000000, bus.wide}, {31'h00000000, e[32]});
        end
    end

    initial begin
        repeat (16) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        foreach (seed[i]) begin
            if (i < 4) begin
                rd(dcd_pkg::IDX_C0_SA + 16'(2 * (i % 2)) + 16'(8 * (i / 2)), 16'h0000);
            end
        end
        rd(dcd_pkg::IDX_EN, 16'h0000);
        rd(dcd_pkg::IDX_STAT, 16'h0000);
        rd(16'hf730, 16'h0000);
        sel <= 4'h1;
        wr(dcd_pkg::IDX_C0_SA, 16'h12ab);
        // byte lane check: a single upper byte write keeps the lower byte
        @(posedge clk_sys_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= 1'b1;
        adr <= {dcd_pkg::IDX_C0_SA, 2'b00};
        sel <= 4'h2;
        dat <= 32'h00003400;
        do @(posedge clk_sys_i); while (wb_ack_o !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        rd(dcd_pkg::IDX_C0_SA, 16'h34ab);
        // channel 0: byte unit, source increments, destination fixed, two transfers
        wr(dcd_pkg::IDX_C0_MODE, 16'h0001);
        wr(dcd_pkg::IDX_C0_CNT, 16'h0002);
        wr(dcd_pkg::IDX_C0_SA, 16'h1000);
        wr(dcd_pkg::IDX_C0_DA, 16'h2001);
        wr(dcd_pkg::IDX_EN, 16'h0001);
        wq.push_back(ew(1'b0, 16'h2001, 16'h1000));
        pulse(2'b01);
        drain();
        rd(dcd_pkg::IDX_STAT, 16'h0000);
        wq.push_back(ew(1'b0, 16'h2001, 16'h1001));
        pulse(2'b01);
        drain();
        rd(dcd_pkg::IDX_EN, 16'h0000);
        rd(dcd_pkg::IDX_STAT, 16'h0001);
        rd(dcd_pkg::IDX_C0_SA, 16'h1002);
        rd(dcd_pkg::IDX_C0_DA, 16'h2001);
        // channel 1: word unit on odd addresses, source down, destination up
        wr(dcd_pkg::IDX_C1_MODE, 16'h0016);
        wr(dcd_pkg::IDX_C1_CNT, 16'h0002);
        wr(dcd_pkg::IDX_C1_SA, 16'h3005);
        wr(dcd_pkg::IDX_C1_DA, 16'h4003);
        wr(dcd_pkg::IDX_EN, 16'h0002);
        wq.push_back(ew(1'b1, 16'h4002, 16'h3004));
        pulse(2'b10);
        drain();
        wq.push_back(ew(1'b1, 16'h4004, 16'h3002));
        pulse(2'b10);
        drain();
        // enable refused while done flag stands; clear is per channel
        wr(dcd_pkg::IDX_EN, 16'h0001);
        rd(dcd_pkg::IDX_EN, 16'h0000);
        wr(dcd_pkg::IDX_CLR, 16'h0002);
        rd(dcd_pkg::IDX_STAT, 16'h0001);
        wr(dcd_pkg::IDX_CLR, 16'h0001);
        rd(dcd_pkg::IDX_STAT, 16'h0000);
        rd(dcd_pkg::IDX_CLR, 16'h0000);
        // fixed channel: channel 1 request ignored while channel 0 runs
        wr(dcd_pkg::IDX_C0_CNT, 16'h0002);
        wr(dcd_pkg::IDX_C0_SA, 16'h1200);
        wr(dcd_pkg::IDX_C1_CNT, 16'h0001);
        wr(dcd_pkg::IDX_C1_SA, 16'h3200);
        wr(dcd_pkg::IDX_C1_DA, 16'h4200);
        wr(dcd_pkg::IDX_EN, 16'h0080);
        rd(dcd_pkg::IDX_EN, 16'h0080);
        wr(dcd_pkg::IDX_EN, 16'h0083);
        wr(dcd_pkg::IDX_EN, 16'h0003);
        rd(dcd_pkg::IDX_EN, 16'h0083);
        wq.push_back(ew(1'b0, 16'h2001, 16'h1200));
        pulse(2'b01);
        pulse(2'b10);
        drain();
        rd(dcd_pkg::IDX_STAT, 16'h0100);
        wq.push_back(ew(1'b0, 16'h2001, 16'h1201));
        pulse(2'b01);
        drain();
        wq.push_back(ew(1'b1, 16'h4200, 16'h3200));
        pulse(2'b10);
        drain();
        rd(dcd_pkg::IDX_STAT, 16'h0003);
        // free channels: simultaneous requests, channel 0 goes first
        wr(dcd_pkg::IDX_CLR, 16'h0003);
        wr(dcd_pkg::IDX_C0_MODE, 16'h0000);
        wr(dcd_pkg::IDX_C1_MODE, 16'h0010);
        wr(dcd_pkg::IDX_C0_CNT, 16'h0001);
        wr(dcd_pkg::IDX_C1_CNT, 16'h0001);
        wr(dcd_pkg::IDX_C0_SA, 16'h1100);
        wr(dcd_pkg::IDX_C0_DA, 16'h2100);
        wr(dcd_pkg::IDX_C1_SA, 16'h3100);
        wr(dcd_pkg::IDX_C1_DA, 16'h4100);
        wr(dcd_pkg::IDX_EN, 16'h0003);
        rd(dcd_pkg::IDX_EN, 16'h0003);
        wq.push_back(ew(1'b0, 16'h2100, 16'h1100));
        wq.push_back(ew(1'b1, 16'h4100, 16'h3100));
        pulse(2'b11);
        drain();
        rd(dcd_pkg::IDX_STAT, 16'h0003);
        // software stop: a later request must start nothing
        wr(dcd_pkg::IDX_CLR, 16'h0003);
        wr(dcd_pkg::IDX_C0_CNT, 16'h0002);
        wr(dcd_pkg::IDX_EN, 16'h0001);
        // software request bit starts one transfer, one count left over
        wq.push_back(ew(1'b0, 16'h2100, 16'h1100));
        wr(dcd_pkg::IDX_C0_MODE, 16'h8000);
        drain();
        wr(dcd_pkg::IDX_EN, 16'h0000);
        pulse(2'b01);
        repeat (12) @(posedge clk_sys_i);
        rd(dcd_pkg::IDX_STAT, 16'h0000);
        chk("irq_count", irq_cnt, 6);
        end_sim();
    end
endmodule // tb_top
`default_nettype wire

// [src/dcd_pkg.sv]
// constants and types shared by the dual channel dma control block
package dcd_pkg;
    localparam int unsigned ADR_W     = 18;
    localparam int unsigned IDX_W     = 16;
    localparam int unsigned CNT_W     = 10;
    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_C0_MODE = 16'hf700;
    localparam logic [15:0] IDX_C0_CNT  = 16'hf702;
    localparam logic [15:0] IDX_C0_SA   = 16'hf704;
    localparam logic [15:0] IDX_C0_DA   = 16'hf706;
    localparam logic [15:0] IDX_C1_MODE = 16'hf708;
    localparam logic [15:0] IDX_C1_CNT  = 16'hf70a;
    localparam logic [15:0] IDX_C1_SA   = 16'hf70c;
    localparam logic [15:0] IDX_C1_DA   = 16'hf70e;
    localparam logic [15:0] IDX_EN      = 16'hf720;
    localparam logic [15:0] IDX_STAT    = 16'hf722;
    localparam logic [15:0] IDX_CLR     = 16'hf724;
    // field positions and mode register width
    localparam int unsigned EN_FIX_BIT   = 7;
    localparam int unsigned MODE_DS_BIT  = 4;
    localparam int unsigned MODE_DA_LSB  = 2;
    localparam int unsigned MODE_SA_LSB  = 0;
    localparam int unsigned MODE_SWR_BIT = 15;
    localparam int unsigned STAT_ACT_LSB = 8;
    localparam int unsigned MODE_W       = 5;
    // reset values and encodings
    localparam logic [15:0]      RST_ADDR  = 16'h0000;
    localparam logic [CNT_W-1:0] RST_CNT   = 10'h000;
    localparam logic [CNT_W-1:0] CNT_LAST  = 10'h001;
    localparam logic [CNT_W-1:0] CNT_ONE   = 10'h001;
    localparam logic [MODE_W-1:0] RST_MODE = 5'h00;
    localparam logic [1:0]  AM_FIXED  = 2'h0;
    localparam logic [1:0]  AM_INC    = 2'h1;
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RD   = 3'b010,
        ST_WR   = 3'b100
    } dcd_state_t;

    // request towards the shared data bus
    typedef struct packed {
        logic        req;
        logic        we;
        logic        wide;
        logic [15:0] addr;
        logic [15:0] wdata;
    } dcd_mbus_t;
endpackage

// [src/dcd_top.sv]
// dual channel dma control: registers, arbitration and transfer sequencer
`timescale 1ns/1ps
`default_nettype none

module dcd_top (
    input  wire logic                     clk_sys_i,
    input  wire logic                     rst_n_i,
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    input  wire logic                     wb_we_i,
    input  wire logic [dcd_pkg::ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]               wb_sel_i,
    input  wire logic [31:0]              wb_dat_i,
    output logic      [31:0]              wb_dat_o,
    output logic                          wb_ack_o,
    input  wire logic [1:0]               xfer_req_i,
    input  wire logic                     cpu_bus_busy_i,
    input  wire logic [15:0]              dma_rdata_i,
    output dcd_pkg::dcd_mbus_t            dma_bus_o,
    output logic                          dma_complete_irq_o
);
    logic [15:0]                  sa_ff [2];
    logic [15:0]                  da_ff [2];
    logic [dcd_pkg::MODE_W-1:0]   mode_ff [2];
    logic [dcd_pkg::CNT_W-1:0]    cnt_ff [2];
    logic [1:0]                   en_ff;
    logic                         fix_ff;
    logic [1:0]                   done_ff;
    logic [1:0]                   pend_ff;
    logic                         older_ff;
    logic [1:0]                   lock_ff;
    dcd_pkg::dcd_state_t          state_ff;
    logic                         cur_ff;
    logic [15:0]                  rbuf_ff;
    logic                         ack_ff;
    logic [31:0]                  rdat_ff;
    logic                         irq_ff;

    logic [dcd_pkg::IDX_W-1:0]    idx;
    logic                         wr_go;
    logic [1:0]                   swreq;
    logic [1:0]                   accept;
    logic                         start;
    logic                         pick;
    logic                         step_done;
    logic                         fin;
    logic                         abort;
    logic                         wide;
    logic [15:0]                  rd_mux;

    function automatic logic [15:0] dcd_step(input logic [15:0] a, input logic [1:0] m,
                                             input logic w);
        logic [15:0] d;
        d = w ? dcd_pkg::STEP_WORD : dcd_pkg::STEP_BYTE;
        case (m)
            dcd_pkg::AM_FIXED: dcd_step = a;
            dcd_pkg::AM_INC:   dcd_step = a + d;
            default:           dcd_step = a - d;
        endcase
    endfunction

    function automatic logic [15:0] dcd_merge(input logic [15:0] o, input logic [15:0] d,
                                              input logic [1:0] s);
        dcd_merge = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
    endfunction

    function automatic logic [15:0] dcd_even(input logic [15:0] a, input logic w);
        dcd_even = w ? {a[15:1], 1'b0} : a;
    endfunction

    // bus slave: one wait state, writes land on the acknowledged edge
    assign idx      = wb_adr_i[dcd_pkg::ADR_W-1:2];
    assign wr_go    = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff;
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdat_ff;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_ff  <= 1'b0;
            rdat_ff <= 32'h0000_0000;
        end else begin
            ack_ff  <= wb_cyc_i & wb_stb_i & ~ack_ff;
            rdat_ff <= {16'h0000, rd_mux};
        end
    end

    always_comb begin
        rd_mux = 16'h0000;
        case (idx)
            dcd_pkg::IDX_C0_MODE: rd_mux = {11'h000, mode_ff[0]};
            dcd_pkg::IDX_C1_MODE: rd_mux = {11'h000, mode_ff[1]};
            dcd_pkg::IDX_C0_CNT:  rd_mux = {6'h00, cnt_ff[0]};
            dcd_pkg::IDX_C1_CNT:  rd_mux = {6'h00, cnt_ff[1]};
            dcd_pkg::IDX_C0_SA:   rd_mux = sa_ff[0];
            dcd_pkg::IDX_C0_DA:   rd_mux = da_ff[0];
            dcd_pkg::IDX_C1_SA:   rd_mux = sa_ff[1];
            dcd_pkg::IDX_C1_DA:   rd_mux = da_ff[1];
            dcd_pkg::IDX_EN:      rd_mux = {8'h00, fix_ff, 5'h00, en_ff};
            // active bits masked unless the channel is fixed
            dcd_pkg::IDX_STAT:    rd_mux = {6'h00, fix_ff ? lock_ff : 2'h0, 6'h00, done_ff};
            default:              rd_mux = 16'h0000; // clear reg and holes read zero
        endcase
    end

    // software request pulses from the mode register's write-only bit
    assign swreq[0] = wr_go & (idx == dcd_pkg::IDX_C0_MODE) & wb_sel_i[1]
                      & wb_dat_i[dcd_pkg::MODE_SWR_BIT];
    assign swreq[1] = wr_go & (idx == dcd_pkg::IDX_C1_MODE) & wb_sel_i[1]
                      & wb_dat_i[dcd_pkg::MODE_SWR_BIT];

    // a locked channel shuts the other one out
    assign accept[0] = (xfer_req_i[0] | swreq[0]) & en_ff[0] & ~(fix_ff & lock_ff[1]);
    assign accept[1] = (xfer_req_i[1] | swreq[1]) & en_ff[1] & ~(fix_ff & lock_ff[0]);

    // older pending request first, channel 0 on a tie
    assign pick  = (pend_ff == 2'b11) ? older_ff : pend_ff[1];
    // processor keeps the bus; dma only starts on a free bus
    assign start = (state_ff == dcd_pkg::ST_IDLE) & (|pend_ff) & ~cpu_bus_busy_i;

    assign wide      = mode_ff[cur_ff][dcd_pkg::MODE_DS_BIT];
    assign step_done = (state_ff == dcd_pkg::ST_WR) & ~cpu_bus_busy_i & en_ff[cur_ff];
    assign fin       = step_done & (cnt_ff[cur_ff] == dcd_pkg::CNT_LAST);
    // channel disabled mid transfer drops it; addresses and count keep their values
    assign abort     = (state_ff != dcd_pkg::ST_IDLE) & ~en_ff[cur_ff];

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff <= dcd_pkg::ST_IDLE;
            cur_ff   <= 1'b0;
            rbuf_ff  <= 16'h0000;
        end else begin
            case (state_ff)
                dcd_pkg::ST_IDLE: begin
                    if (start) begin
                        state_ff <= dcd_pkg::ST_RD;
                        cur_ff   <= pick;
                    end
                end
                dcd_pkg::ST_RD: begin
                    if (abort) begin
                        state_ff <= dcd_pkg::ST_IDLE;
                    end else if (!cpu_bus_busy_i) begin
                        state_ff <= dcd_pkg::ST_WR;
                        rbuf_ff  <= dma_rdata_i;
                    end
                end
                dcd_pkg::ST_WR: begin
                    if (abort || step_done) begin
                        state_ff <= dcd_pkg::ST_IDLE;
                    end
                end
                default: state_ff <= dcd_pkg::ST_IDLE;
            endcase
        end
    end

    // pending requests; repeats before the read phase are absorbed
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pend_ff  <= 2'b00;
            older_ff <= 1'b0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                // under the fix bit a shut-out request is dropped, not deferred: left
                // pending it would run between the locked channel's transfers
                if (!en_ff[c] || (start && (pick == c[0] || fix_ff))
                    || (fix_ff && lock_ff[~c[0]])) begin
                    pend_ff[c] <= 1'b0;
                end else if (accept[c]) begin
                    pend_ff[c] <= 1'b1;
                end
            end
            case (pend_ff)
                2'b01:   older_ff <= 1'b0;
                2'b10:   older_ff <= 1'b1;
                2'b11:   older_ff <= older_ff;
                default: older_ff <= accept[1] & ~accept[0];
            endcase
        end
    end

    // channel lock under the fix bit, held until the count completes or the channel is disabled
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lock_ff <= 2'b00;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (!en_ff[c] || (fin && cur_ff == c[0])) begin
                    lock_ff[c] <= 1'b0;
                end else if (start && fix_ff && pick == c[0]) begin
                    lock_ff[c] <= 1'b1;
                end
            end
        end
    end

    // enable, fix and done flags
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            en_ff   <= 2'b00;
            fix_ff  <= 1'b0;
            done_ff <= 2'b00;
        end else begin
            if (wr_go && idx == dcd_pkg::IDX_EN && wb_sel_i[0] && en_ff == 2'b00) begin
                fix_ff <= wb_dat_i[dcd_pkg::EN_FIX_BIT];
            end
            for (int c = 0; c < 2; c++) begin
                if (fin && cur_ff == c[0]) begin
                    en_ff[c]   <= 1'b0;
                    done_ff[c] <= 1'b1;
                end else begin
                    if (wr_go && idx == dcd_pkg::IDX_EN && wb_sel_i[0]) begin
                        en_ff[c] <= wb_dat_i[c] & ~done_ff[c];
                    end
                    if (wr_go && idx == dcd_pkg::IDX_CLR && wb_sel_i[0] && wb_dat_i[c]) begin
                        done_ff[c] <= 1'b0;
                    end
                end
            end
        end
    end

    // address, mode and count registers; hardware stepping beats a bus write
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int c = 0; c < 2; c++) begin
                sa_ff[c]   <= dcd_pkg::RST_ADDR;
                da_ff[c]   <= dcd_pkg::RST_ADDR;
                mode_ff[c] <= dcd_pkg::RST_MODE;
                cnt_ff[c]  <= dcd_pkg::RST_CNT;
            end
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (step_done && cur_ff == c[0]) begin
                    sa_ff[c]  <= dcd_step(sa_ff[c],
                        mode_ff[c][dcd_pkg::MODE_SA_LSB +: 2], wide);
                    da_ff[c]  <= dcd_step(da_ff[c],
                        mode_ff[c][dcd_pkg::MODE_DA_LSB +: 2], wide);
                    cnt_ff[c] <= cnt_ff[c] - dcd_pkg::CNT_ONE;
                end else if (wr_go) begin
                    if (idx == (c[0] ? dcd_pkg::IDX_C1_SA : dcd_pkg::IDX_C0_SA)) begin
                        sa_ff[c] <= dcd_merge(sa_ff[c], wb_dat_i[15:0], wb_sel_i[1:0]);
                    end
                    if (idx == (c[0] ? dcd_pkg::IDX_C1_DA : dcd_pkg::IDX_C0_DA)) begin
                        da_ff[c] <= dcd_merge(da_ff[c], wb_dat_i[15:0], wb_sel_i[1:0]);
                    end
                    if (idx == (c[0] ? dcd_pkg::IDX_C1_CNT : dcd_pkg::IDX_C0_CNT)
                        && !en_ff[c]) begin
                        // count field narrower than the word; top bits dropped on purpose
                        cnt_ff[c] <= dcd_pkg::CNT_W'(dcd_merge({6'h00, cnt_ff[c]},
                                                     wb_dat_i[15:0], wb_sel_i[1:0]));
                    end
                    if (idx == (c[0] ? dcd_pkg::IDX_C1_MODE : dcd_pkg::IDX_C0_MODE)
                        && wb_sel_i[0]) begin
                        mode_ff[c] <= wb_dat_i[dcd_pkg::MODE_W-1:0];
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= fin;
        end
    end
    assign dma_complete_irq_o = irq_ff;

    // bus request is withdrawn while the processor holds the bus
    always_comb begin
        dma_bus_o.req   = (state_ff != dcd_pkg::ST_IDLE) & ~cpu_bus_busy_i & ~abort;
        dma_bus_o.we    = (state_ff == dcd_pkg::ST_WR);
        dma_bus_o.wide  = wide;
        dma_bus_o.addr  = (state_ff == dcd_pkg::ST_WR) ? dcd_even(da_ff[cur_ff], wide)
                                                       : dcd_even(sa_ff[cur_ff], wide);
        dma_bus_o.wdata = rbuf_ff;
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    addr_step_a: assert property (step_done && cur_ff == 1'b0 && !wide
        && mode_ff[0][1:0] == dcd_pkg::AM_INC |=> sa_ff[0] == $past(sa_ff[0]) + 16'h0001)
        else $error("source address did not step by one");
    even_addr_a: assert property (dma_bus_o.req && dma_bus_o.wide |-> !dma_bus_o.addr[0])
        else $error("odd address on 16-bit transfer");
    fix_lock_a: assert property (fix_ff && lock_ff[0] && state_ff == dcd_pkg::ST_IDLE
        && start |=> !cur_ff)
        else $error("other channel served while fixed");
    tie_break_a: assert property (start && pend_ff == 2'b11 && !older_ff |=> !cur_ff)
        else $error("tie not won by channel 0");
    fix_frozen_a: assert property (en_ff != 2'b00 |=> fix_ff == $past(fix_ff))
        else $error("fix bit changed while enabled");
    done_update_a: assert property (fin && !cur_ff |=> !en_ff[0] && done_ff[0]
        && dma_complete_irq_o)
        else $error("completion not signalled together");
    en_refused_a: assert property (done_ff[1] && !en_ff[1] |=> !en_ff[1])
        else $error("enable accepted with done flag set");
    sta_mask_a: assert property (!fix_ff && idx == dcd_pkg::IDX_STAT
        && wb_cyc_i && wb_stb_i |=> wb_dat_o[9:8] == 2'b00)
        else $error("active bits visible without fix");
    clr_flag_a: assert property (wr_go && idx == dcd_pkg::IDX_CLR && wb_sel_i[0]
        && wb_dat_i[0] && !(fin && !cur_ff) |=> !done_ff[0])
        else $error("done flag not cleared");
    cpu_hold_a: assert property (cpu_bus_busy_i |-> !dma_bus_o.req)
        else $error("dma drove bus under processor");
    fix_drop_a: assert property (fix_ff && lock_ff[0] |-> !pend_ff[1])
        else $error("shut out request kept pending");
    stop_drop_a: assert property (abort |=> state_ff == dcd_pkg::ST_IDLE)
        else $error("stopped channel kept the bus");

    two_chan_c: cover property (pend_ff == 2'b11 ##[1:20] fin);
    done_c:     cover property (fin && cur_ff);
    held_c:     cover property (state_ff == dcd_pkg::ST_RD && cpu_bus_busy_i [*2]);
    sw_req_c:   cover property (swreq[0] ##1 pend_ff[0]);
    fix_hold_c: cover property (fix_ff && lock_ff[0] && xfer_req_i[1]);
endmodule // dcd_top

`default_nettype wire
